// ### core/tdt_pkg.sv
// package for the 10-bit down-count timer with pwm output
// assumes a single clock domain; registers are reached over a plain strobe port
package tdt_pkg;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h07;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h08;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h1a;
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'h1b;
  localparam logic [7:0] ADDR_CONTROL_TWO = 8'h1c;
  localparam logic [7:0] ADDR_DUTY_LOW = 8'h1d;
  localparam logic [7:0] ADDR_DIV_READBACK = 8'h1e;
  localparam logic [7:0] ADDR_HIGH_BITS = 8'h1f;
  // field positions
  localparam int BIT_RUN = 0;
  localparam int BIT_RELOAD_SEL = 1;
  localparam int BIT_ONE_SHOT = 2;
  localparam int BIT_FAST_OSC = 3;
  localparam int BIT_POLARITY = 6;
  localparam int BIT_PIN_EN = 7;
  localparam int BIT_SOURCE = 5;
  localparam int BIT_EDGE = 4;
  localparam int BIT_BYPASS_N = 3;
  localparam int BIT_IRQ = 5;
  // reset values
  localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
  localparam logic [5:0] RST_CONTROL_TWO = 6'h3f;
  localparam logic [7:0] RST_DIV_COUNT = 8'hff;
  localparam logic [9:0] CNT_TOP = 10'h3ff;
  localparam logic [9:0] CNT_ZERO = 10'h000;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tdt_bus_req_t;
endpackage : tdt_pkg

// ### core/tdt_timer.sv
// 10-bit down-count timer with prescaler and pwm output
// assumes all inputs synchronous to clk; clock sources arrive as level inputs sampled on clk
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module tdt_timer (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire tdt_pkg::tdt_bus_req_t bus,
  output logic [7:0] rdata,
  // clock sources
  input wire logic instr_tick,
  input wire logic fast_osc_tick,
  input wire logic ext_count_pin,
  // pwm pin and interrupt
  output logic wave_out,
  output logic wave_oe_n,
  output logic irq
);
  import tdt_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] control_one;
  logic [5:0] control_two;
  logic [9:0] reload;
  logic [9:0] duty;
  logic [9:0] count;
  logic [7:0] div_cnt;
  logic irq_en;
  logic irq_flag;
  logic ext_prev;
  logic stopped;

  logic wr_count, wr_high, wr_c1, wr_c2, wr_duty, wr_en, wr_flag;
  assign wr_count = bus.wr && bus.addr == ADDR_COUNT_LOW;
  assign wr_high = bus.wr && bus.addr == ADDR_HIGH_BITS;
  assign wr_c1 = bus.wr && bus.addr == ADDR_CONTROL_ONE;
  assign wr_c2 = bus.wr && bus.addr == ADDR_CONTROL_TWO;
  assign wr_duty = bus.wr && bus.addr == ADDR_DUTY_LOW;
  assign wr_en = bus.wr && bus.addr == ADDR_IRQ_ENABLE;
  assign wr_flag = bus.wr && bus.addr == ADDR_IRQ_FLAG;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      control_one <= RST_CONTROL_ONE;
    end else if (wr_c1) begin
      control_one <= bus.wdata & 8'hcf;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      control_two <= RST_CONTROL_TWO;
    end else if (wr_c2) begin
      control_two <= bus.wdata[5:0];
    end
  end

  // reload low byte is written with the count register; high bits via high register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reload <= CNT_ZERO;
    end else if (wr_count) begin
      reload[7:0] <= bus.wdata;
    end else if (wr_high) begin
      reload[9:8] <= bus.wdata[5:4];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      duty <= CNT_ZERO;
    end else if (wr_duty) begin
      duty[7:0] <= bus.wdata;
    end else if (wr_high) begin
      duty[9:8] <= bus.wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_en <= 1'b0;
    end else if (wr_en) begin
      irq_en <= bus.wdata[BIT_IRQ];
    end
  end

  // ----------------------------------------
  // clock source and edge selection
  // ----------------------------------------
  logic ext_edge, src_tick, div_tick, tmr_tick;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_count_pin;
    end
  end

  assign ext_edge = control_two[BIT_EDGE] ? (ext_prev && !ext_count_pin) : (!ext_prev && ext_count_pin);

  always_comb begin
    if (control_one[BIT_FAST_OSC]) begin
      src_tick = fast_osc_tick;
    end else if (control_two[BIT_SOURCE]) begin
      src_tick = ext_edge;
    end else begin
      src_tick = instr_tick;
    end
  end

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  // rate code n needs 2^(n+1) source ticks; match the low n+1 bits of the next free count against all ones
  function automatic logic div_wrap(input logic [7:0] cnt, input logic [2:0] rate);
    logic [7:0] mask;
    mask = 8'hff >> (3'h7 - rate);
    return (cnt & mask) == mask;
  endfunction : div_wrap

  logic run;
  assign run = control_one[BIT_RUN];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_cnt <= RST_DIV_COUNT;
    end else if (run && src_tick && !control_two[BIT_BYPASS_N]) begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  assign div_tick = control_two[BIT_BYPASS_N] ? src_tick
                  : (src_tick && div_wrap(div_cnt + 8'h01, control_two[2:0]));
  assign tmr_tick = run && div_tick && !stopped;

  // ----------------------------------------
  // down-counter
  // ----------------------------------------
  logic underflow;
  assign underflow = tmr_tick && count == CNT_ZERO;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= CNT_TOP;
      stopped <= 1'b0;
    end else if (wr_count) begin
      count <= {reload[9:8], bus.wdata};
      stopped <= 1'b0;
    end else if (count == CNT_ZERO && tmr_tick && control_one[BIT_ONE_SHOT]) begin
      stopped <= 1'b1;
    end else if (underflow) begin
      count <= control_one[BIT_RELOAD_SEL] ? reload : CNT_TOP;
    end else if (tmr_tick) begin
      count <= count - 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_flag <= 1'b0;
    end else if (underflow) begin
      irq_flag <= 1'b1;
    end else if (wr_flag && !bus.wdata[BIT_IRQ]) begin
      irq_flag <= 1'b0;
    end
  end

  assign irq = irq_flag && irq_en;

  // ----------------------------------------
  // pwm
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wave_out <= 1'b0;
    end else begin
      wave_out <= (count < duty) ^ control_one[BIT_POLARITY];
    end
  end

  assign wave_oe_n = !control_one[BIT_PIN_EN];

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        ADDR_COUNT_LOW: rdata <= count[7:0];
        ADDR_CONTROL_ONE: rdata <= control_one;
        ADDR_CONTROL_TWO: rdata <= {2'h0, control_two};
        ADDR_DIV_READBACK: rdata <= div_cnt;
        ADDR_HIGH_BITS: rdata <= {2'h0, count[9:8], 2'h0, duty[9:8]};
        ADDR_IRQ_ENABLE: rdata <= {2'h0, irq_en, 5'h00};
        ADDR_IRQ_FLAG: rdata <= {2'h0, irq_flag, 5'h00};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_zero_tick;
    count == CNT_ZERO && tmr_tick && !wr_count;
  endsequence

  load_count_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_count |=> count == {$past(reload[9:8]), $past(bus.wdata)}) else $error("count load wrong");
  roll_top_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_zero_tick and !control_one[BIT_ONE_SHOT] and !control_one[BIT_RELOAD_SEL] |=> count == CNT_TOP)
    else $error("no roll to top");
  roll_reload_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_zero_tick and !control_one[BIT_ONE_SHOT] and control_one[BIT_RELOAD_SEL] |=> count == $past(reload))
    else $error("no reload");
  one_shot_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_zero_tick and control_one[BIT_ONE_SHOT] |=> stopped && count == CNT_ZERO) else $error("one-shot ran on");
  hold_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    !run && !wr_count |=> $stable(count) && $stable(div_cnt)) else $error("counter moved while off");
  flag_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    underflow |=> irq_flag) else $error("flag not set");
  read_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    bus.rd && bus.addr == ADDR_COUNT_LOW |=> rdata == $past(count[7:0])) else $error("count read wrong");
  // the wave flop samples polarity one edge before it is seen, so compare against the old polarity
  wave_level_a: assert property (@(posedge clk) disable iff (sys_rst)
    $stable(control_one) |=> wave_out == (($past(count) < $past(duty)) ^ $past(control_one[BIT_POLARITY])))
    else $error("pwm level wrong");
  pin_enable_a: assert property (@(posedge clk) disable iff (sys_rst)
    wave_oe_n == !control_one[BIT_PIN_EN]) else $error("pin enable wrong");

  // ----------------------------------------
  // register file checks
  // ----------------------------------------
  sequence s_flag_clear;
    wr_flag && !bus.wdata[BIT_IRQ];
  endsequence

  ctrl_one_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_c1 |=> control_one == ($past(bus.wdata) & 8'hcf)) else $error("control one write wrong");
  ctrl_two_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_c2 |=> control_two == $past(bus.wdata[5:0])) else $error("control two write wrong");
  reload_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_high |=> reload[9:8] == $past(bus.wdata[5:4])) else $error("reload high bits wrong");
  duty_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_high |=> duty[9:8] == $past(bus.wdata[1:0])) else $error("duty high bits wrong");
  duty_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_duty |=> duty[7:0] == $past(bus.wdata)) else $error("duty low byte wrong");
  irq_en_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_en |=> irq_en == $past(bus.wdata[BIT_IRQ])) else $error("irq enable write wrong");
  read_div_a: assert property (@(posedge clk) disable iff (sys_rst)
    bus.rd && bus.addr == ADDR_DIV_READBACK |=> rdata == $past(div_cnt)) else $error("divider read wrong");
  read_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    bus.rd && bus.addr == ADDR_HIGH_BITS |=> rdata[5:4] == $past(count[9:8]) && rdata[1:0] == $past(duty[9:8]))
    else $error("high bits read wrong");
  read_duty_a: assert property (@(posedge clk) disable iff (sys_rst)
    bus.rd && bus.addr == ADDR_DUTY_LOW |=> rdata == 8'h00) else $error("duty register readable");
  rdata_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    !bus.rd |=> rdata == 8'h00) else $error("read data not idle");

  // ----------------------------------------
  // clock source checks
  // ----------------------------------------
  sequence s_ext_sel;
    !control_one[BIT_FAST_OSC] && control_two[BIT_SOURCE];
  endsequence

  fast_src_a: assert property (@(posedge clk) disable iff (sys_rst)
    control_one[BIT_FAST_OSC] |-> src_tick == fast_osc_tick) else $error("fast source not used");
  ext_src_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_ext_sel |-> src_tick == ext_edge) else $error("external source not used");
  int_src_a: assert property (@(posedge clk) disable iff (sys_rst)
    !control_one[BIT_FAST_OSC] && !control_two[BIT_SOURCE] |-> src_tick == instr_tick)
    else $error("instruction source not used");
  ext_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_ext_sel ##0 (control_two[BIT_EDGE] && $fell(ext_count_pin)) |-> src_tick)
    else $error("falling edge missed");
  ext_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_ext_sel ##0 (!control_two[BIT_EDGE] && $rose(ext_count_pin)) |-> src_tick)
    else $error("rising edge missed");

  // ----------------------------------------
  // prescaler checks
  // ----------------------------------------
  bypass_tick_a: assert property (@(posedge clk) disable iff (sys_rst)
    control_two[BIT_BYPASS_N] |-> div_tick == src_tick) else $error("bypass not direct");
  bypass_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    control_two[BIT_BYPASS_N] |=> $stable(div_cnt)) else $error("divider moved while bypassed");
  div_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    run && src_tick && !control_two[BIT_BYPASS_N] |=> div_cnt == $past(div_cnt) + 8'h01)
    else $error("divider did not step");
  // rate 000 passes every second source tick, rate 111 one in 256
  rate_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    !control_two[BIT_BYPASS_N] && control_two[2:0] == 3'h0 && src_tick |-> div_tick == !div_cnt[0])
    else $error("rate 1:2 wrong");
  rate_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    !control_two[BIT_BYPASS_N] && control_two[2:0] == 3'h7 && src_tick |-> div_tick == (div_cnt == 8'hfe))
    else $error("rate 1:256 wrong");

  // ----------------------------------------
  // counter and flag checks
  // ----------------------------------------
  count_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    tmr_tick && count != CNT_ZERO && !wr_count |=> count == $past(count) - 10'h001)
    else $error("count did not step");
  no_tick_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !run |-> !tmr_tick && !underflow) else $error("tick while off");
  stop_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    stopped && !wr_count |=> $stable(count)) else $error("stopped count moved");
  flag_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    irq_flag && !(wr_flag && !bus.wdata[BIT_IRQ]) |=> irq_flag) else $error("flag dropped");
  flag_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_flag_clear ##0 !underflow |=> !irq_flag) else $error("flag not cleared");
  irq_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    !irq_en |-> !irq) else $error("irq not gated");
endmodule : tdt_timer
`default_nettype wire

// ### testbench/tdt_timer_tb_top.sv
// self-checking bench for the 10-bit down-count timer with pwm output
// assumes tdt_pkg and tdt_timer are compiled first; instruction and fast ticks are one-cycle pulses, the external pin is toggled
`timescale 1ns/100ps
`default_nettype none
module tdt_timer_tb_top;
  import tdt_pkg::*;
  logic clk;
  logic sys_rst;
  tdt_bus_req_t bus;
  logic [7:0] rdata;
  logic instr_tick;
  logic fast_osc_tick;
  logic ext_count_pin;
  logic wave_out;
  logic wave_oe_n;
  logic irq;
  int miscompares;
  int checks;

  tdt_timer DUT (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .instr_tick(instr_tick),
    .fast_osc_tick(fast_osc_tick), .ext_count_pin(ext_count_pin), .wave_out(wave_out),
    .wave_oe_n(wave_oe_n), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // --------------------------------
  // access tasks
  // --------------------------------
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check({2'h0, v & mask}, {2'h0, exp});
  endtask : rchk

  task automatic cchk(input logic [9:0] exp);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(ADDR_COUNT_LOW, lo);
    rd(ADDR_HIGH_BITS, hi);
    check({hi[5:4], lo}, exp);
  endtask : cchk

  // high bits first: the count low write takes reload bits 9:8 from there
  task automatic load(input logic [9:0] v);
    wr(ADDR_HIGH_BITS, {2'h0, v[9:8], 4'h0});
    wr(ADDR_COUNT_LOW, v[7:0]);
  endtask : load

  // src 0 instruction tick, 1 fast oscillator tick, other: toggle the external pin
  task automatic ticks(input int n, input int src);
    repeat (n) begin
      @(posedge clk);
      case (src)
        0: instr_tick <= 1'b1;
        1: fast_osc_tick <= 1'b1;
        default: ext_count_pin <= ~ext_count_pin;
      endcase
      @(posedge clk);
      instr_tick <= 1'b0;
      fast_osc_tick <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask : ticks

  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // --------------------------------
  // watchdog
  // --------------------------------
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  // --------------------------------
  // tests
  // --------------------------------
  initial begin
    sys_rst = 1'b1;
    bus = '0;
    instr_tick = 1'b0;
    fast_osc_tick = 1'b0;
    ext_count_pin = 1'b0;
    miscompares = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(ADDR_CONTROL_ONE, 8'hcf, 8'h00);
    rchk(ADDR_CONTROL_TWO, 8'h3f, 8'h3f);
    rchk(ADDR_DIV_READBACK, 8'hff, 8'hff);
    rchk(ADDR_IRQ_ENABLE, 8'h20, 8'h00);
    rchk(8'h40, 8'hff, 8'h00);
    check({9'h0, wave_oe_n}, 10'h001);
    wr(ADDR_CONTROL_TWO, 8'h08);
    load(10'h105);
    ticks(3, 0);
    cchk(10'h105);
    wr(ADDR_CONTROL_ONE, 8'h01);
    ticks(3, 0);
    cchk(10'h102);
    wr(ADDR_CONTROL_ONE, 8'h09);
    ticks(2, 0);
    cchk(10'h102);
    ticks(2, 1);
    cchk(10'h100);
    wr(ADDR_CONTROL_ONE, 8'h01);
    wr(ADDR_CONTROL_TWO, 8'h28);
    ticks(1, 2);
    cchk(10'h0ff);
    ticks(1, 2);
    cchk(10'h0ff);
    wr(ADDR_CONTROL_TWO, 8'h38);
    ticks(1, 2);
    cchk(10'h0ff);
    ticks(1, 2);
    cchk(10'h0fe);
    // rate is only changed while the divider is bypassed, then the divider is switched in
    wr(ADDR_CONTROL_TWO, 8'h08);
    wr(ADDR_CONTROL_TWO, 8'h00);
    ticks(8, 0);
    cchk(10'h0fa);
    wr(ADDR_CONTROL_TWO, 8'h0a);
    wr(ADDR_CONTROL_TWO, 8'h02);
    ticks(16, 0);
    cchk(10'h0f8);
    wr(ADDR_CONTROL_TWO, 8'h0f);
    wr(ADDR_CONTROL_TWO, 8'h07);
    ticks(256, 0);
    cchk(10'h0f7);
    wr(ADDR_CONTROL_TWO, 8'h0f);
    wr(ADDR_CONTROL_TWO, 8'h08);
    wr(ADDR_IRQ_FLAG, 8'h00);
    load(10'h002);
    ticks(3, 0);
    cchk(10'h3ff);
    rchk(ADDR_IRQ_FLAG, 8'h20, 8'h20);
    check({9'h0, irq}, 10'h000);
    wr(ADDR_IRQ_ENABLE, 8'h20);
    rchk(ADDR_IRQ_ENABLE, 8'h20, 8'h20);
    check({9'h0, irq}, 10'h001);
    wr(ADDR_IRQ_FLAG, 8'h00);
    rchk(ADDR_IRQ_FLAG, 8'h20, 8'h00);
    check({9'h0, irq}, 10'h000);
    wr(ADDR_CONTROL_ONE, 8'h03);
    load(10'h003);
    ticks(4, 0);
    cchk(10'h003);
    wr(ADDR_CONTROL_ONE, 8'h07);
    load(10'h002);
    ticks(5, 0);
    cchk(10'h000);
    wr(ADDR_CONTROL_ONE, 8'h00);
    wr(ADDR_DUTY_LOW, 8'h10);
    load(10'h020);
    rchk(ADDR_DUTY_LOW, 8'hff, 8'h00);
    wr(ADDR_CONTROL_ONE, 8'h81);
    ticks(16, 0);
    check({8'h0, wave_oe_n, wave_out}, 10'h000);
    ticks(1, 0);
    check({9'h0, wave_out}, 10'h001);
    wr(ADDR_CONTROL_ONE, 8'hc1);
    ticks(0, 0);
    check({9'h0, wave_out}, 10'h000);
    wr(ADDR_CONTROL_ONE, 8'h41);
    ticks(0, 0);
    check({9'h0, wave_oe_n}, 10'h001);
    finish_test();
  end
endmodule : tdt_timer_tb_top
`default_nettype wire
